// file: shared/dcc_pkg.sv
package dcc_pkg;
  localparam logic [4:0] DCC_OFF_CTRL1   = 5'h00;
  localparam logic [4:0] DCC_OFF_CTRL2   = 5'h04;
  localparam logic [4:0] DCC_OFF_SHARED  = 5'h08;
  localparam logic [4:0] DCC_OFF_FLAGS   = 5'h0c;
  localparam logic [4:0] DCC_OFF_PORT    = 5'h10;
  localparam logic [4:0] DCC_OFF_ANALOG  = 5'h14;
  localparam logic [4:0] DCC_OFF_DIR     = 5'h18;
  localparam int         DCC_BIT_ON      = 7;
  localparam int         DCC_BIT_RES     = 6;
  localparam int         DCC_BIT_OE      = 5;
  localparam int         DCC_BIT_POL     = 4;
  localparam int         DCC_BIT_REF     = 2;
  localparam int         DCC_BIT_ALTCLK  = 4;
  localparam int         DCC_BIT_HYS1    = 3;
  localparam int         DCC_BIT_HYS2    = 2;
  localparam int         DCC_BIT_GSS     = 1;
  localparam int         DCC_BIT_SYNC    = 0;
  localparam logic [7:0] DCC_CTRL_WMASK  = 8'hb7;
  localparam logic [7:0] DCC_SHARED_WMASK = 8'h1f;
  localparam logic [7:0] DCC_CTRL_RST    = 8'h00;
  localparam logic [7:0] DCC_SHARED_RST  = 8'h02;
  localparam logic [7:0] DCC_ANALOG_RST  = 8'hff;
  localparam logic [7:0] DCC_DIR_RST     = 8'hff;
  localparam logic [1:0] DCC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] DCC_RESP_SLVERR = 2'h2;
endpackage

// file: logic/dcc_top.sv
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module dcc_top
  import dcc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [4:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [4:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        cmp1_raw,
  input  wire logic        cmp2_raw,
  input  wire logic        timer_clk,
  input  wire logic        timer_gate_pin,
  input  wire logic [7:0]  port_pins,
  output logic             cmp1_enable,
  output logic             cmp2_enable,
  output logic             cmp1_ref_select,
  output logic             cmp2_ref_select,
  output logic [1:0]       cmp1_channel_select,
  output logic [1:0]       cmp2_channel_select,
  output logic             cmp1_hysteresis_enable,
  output logic             cmp2_hysteresis_enable,
  output logic             timer_alt_clock_select,
  output logic             cmp1_pin_out,
  output logic             cmp1_pin_oe,
  output logic             cmp2_pin_out,
  output logic             cmp2_pin_oe,
  output logic             timer_gate
);
  logic [7:0] ctrl1;
  logic [7:0] ctrl2;
  logic [7:0] shared_ctl;
  logic [1:0] irq_flag;
  logic [7:0] analog_sel;
  logic [7:0] port_direction;
  logic [1:0] raw_meta;
  logic [1:0] raw_sync;
  logic       cmp1_result;
  logic       cmp2_result;
  logic [1:0] access_latch;
  logic [1:0] cycle_latch;
  logic [1:0] mismatch_q;
  logic       timer_clk_q;
  logic       cmp2_synced_result;
  logic       aw_held;
  logic       w_held;
  logic [4:0] aw_addr_q;
  logic [7:0] w_byte_q;
  logic       w_lane_q;
  logic       do_write;
  logic       rd_take;
  logic [1:0] mismatch;
  logic [1:0] ctrl_access;
  logic [1:0] flag_wr_val;
  logic       flag_wr;

  // Comparator off forces a low result
  function automatic logic cmp_eval(input logic en, input logic raw, input logic inv);
    return en & (raw ^ inv);
  endfunction

  function automatic logic [7:0] ctrl_view(input logic [7:0] c, input logic res);
    logic [7:0] v;
    v = c & DCC_CTRL_WMASK;
    v[DCC_BIT_RES] = res;
    return v;
  endfunction

  assign do_write = aw_held & w_held & ~bvalid;
  assign rd_take  = arvalid & arready;
  assign flag_wr  = do_write & w_lane_q & (aw_addr_q == DCC_OFF_FLAGS);
  assign flag_wr_val = w_byte_q[1:0];
  assign mismatch = access_latch ^ cycle_latch;

  always_comb begin
    ctrl_access[0] = (rd_take & (araddr == DCC_OFF_CTRL1))
                   | (do_write & (aw_addr_q == DCC_OFF_CTRL1));
    ctrl_access[1] = (rd_take & (araddr == DCC_OFF_CTRL2))
                   | (do_write & (aw_addr_q == DCC_OFF_CTRL2));
  end

  // Write address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready   <= 1'b0;
      wready    <= 1'b0;
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_addr_q <= 5'h00;
      w_byte_q  <= 8'h00;
      w_lane_q  <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= DCC_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held   <= 1'b1;
        aw_addr_q <= awaddr;
        awready   <= 1'b0;
      end else if (!aw_held && !bvalid) begin
        awready <= 1'b1;
      end
      if (wvalid && wready) begin
        w_held   <= 1'b1;
        w_byte_q <= wdata[7:0];
        w_lane_q <= wstrb[0];
        wready   <= 1'b0;
      end else if (!w_held && !bvalid) begin
        wready <= 1'b1;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= (aw_addr_q > DCC_OFF_DIR || aw_addr_q[1:0] != 2'h0) ?
                   DCC_RESP_SLVERR : DCC_RESP_OKAY;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Software-written configuration
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl1          <= DCC_CTRL_RST;
      ctrl2          <= DCC_CTRL_RST;
      shared_ctl     <= DCC_SHARED_RST;
      analog_sel     <= DCC_ANALOG_RST;
      port_direction <= DCC_DIR_RST;
    end else if (do_write && w_lane_q) begin
      if (aw_addr_q == DCC_OFF_CTRL1) ctrl1 <= w_byte_q & DCC_CTRL_WMASK;
      if (aw_addr_q == DCC_OFF_CTRL2) ctrl2 <= w_byte_q & DCC_CTRL_WMASK;
      if (aw_addr_q == DCC_OFF_SHARED) shared_ctl <= w_byte_q & DCC_SHARED_WMASK;
      if (aw_addr_q == DCC_OFF_ANALOG) analog_sel <= w_byte_q;
      if (aw_addr_q == DCC_OFF_DIR) port_direction <= w_byte_q;
    end
  end

  // Read data registered at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= DCC_RESP_OKAY;
    end else if (rd_take) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= DCC_RESP_OKAY;
      rdata   <= 32'h0000_0000;
      case (araddr)
        DCC_OFF_CTRL1:  rdata[7:0] <= ctrl_view(ctrl1, cmp1_result);
        DCC_OFF_CTRL2:  rdata[7:0] <= ctrl_view(ctrl2, cmp2_result);
        DCC_OFF_SHARED: rdata[7:0] <= {cmp1_result, cmp2_result, 1'b0, shared_ctl[4:0]};
        DCC_OFF_FLAGS:  rdata[7:0] <= {6'h00, irq_flag};
        DCC_OFF_PORT:   rdata[7:0] <= port_pins & ~analog_sel;
        DCC_OFF_ANALOG: rdata[7:0] <= analog_sel;
        DCC_OFF_DIR:    rdata[7:0] <= port_direction;
        default:        rresp <= DCC_RESP_SLVERR;
      endcase
    end else begin
      if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
      if (!rvalid || rready) begin
        arready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      raw_meta <= 2'b00;
      raw_sync <= 2'b00;
    end else begin
      raw_meta <= {cmp2_raw, cmp1_raw};
      raw_sync <= raw_meta;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp1_result <= 1'b0;
      cmp2_result <= 1'b0;
    end else begin
      cmp1_result <= cmp_eval(ctrl1[DCC_BIT_ON], raw_sync[0], ctrl1[DCC_BIT_POL]);
      cmp2_result <= cmp_eval(ctrl2[DCC_BIT_ON], raw_sync[1], ctrl2[DCC_BIT_POL]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      access_latch <= 2'b00;
      cycle_latch  <= 2'b00;
      mismatch_q   <= 2'b00;
    end else begin
      cycle_latch <= {cmp2_result, cmp1_result};
      mismatch_q  <= mismatch;
      if (ctrl_access[0]) access_latch[0] <= cmp1_result;
      if (ctrl_access[1]) access_latch[1] <= cmp2_result;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_flag <= 2'b00;
    end else begin
      irq_flag <= (flag_wr ? flag_wr_val : irq_flag) | (mismatch & ~mismatch_q);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_clk_q        <= 1'b0;
      cmp2_synced_result <= 1'b0;
    end else begin
      timer_clk_q <= timer_clk;
      if (timer_clk_q && !timer_clk) cmp2_synced_result <= cmp2_result;
    end
  end

  // Pin and analog-side controls; all outputs registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp1_enable            <= 1'b0;
      cmp2_enable            <= 1'b0;
      cmp1_ref_select        <= 1'b0;
      cmp2_ref_select        <= 1'b0;
      cmp1_channel_select    <= 2'b00;
      cmp2_channel_select    <= 2'b00;
      cmp1_hysteresis_enable <= 1'b0;
      cmp2_hysteresis_enable <= 1'b0;
      timer_alt_clock_select <= 1'b0;
      cmp1_pin_out           <= 1'b0;
      cmp1_pin_oe            <= 1'b0;
      cmp2_pin_out           <= 1'b0;
      cmp2_pin_oe            <= 1'b0;
      timer_gate             <= 1'b0;
    end else begin
      cmp1_enable            <= ctrl1[DCC_BIT_ON];
      cmp2_enable            <= ctrl2[DCC_BIT_ON];
      cmp1_ref_select        <= ctrl1[DCC_BIT_REF];
      cmp2_ref_select        <= ctrl2[DCC_BIT_REF];
      cmp1_channel_select    <= ctrl1[1:0];
      cmp2_channel_select    <= ctrl2[1:0];
      cmp1_hysteresis_enable <= shared_ctl[DCC_BIT_HYS1];
      cmp2_hysteresis_enable <= shared_ctl[DCC_BIT_HYS2];
      timer_alt_clock_select <= shared_ctl[DCC_BIT_ALTCLK];
      cmp1_pin_out <= cmp1_result;
      cmp2_pin_out <= cmp2_result;
      cmp1_pin_oe <= ctrl1[DCC_BIT_OE] & ctrl1[DCC_BIT_ON] & ~port_direction[0];
      cmp2_pin_oe <= ctrl2[DCC_BIT_OE] & ctrl2[DCC_BIT_ON] & ~port_direction[1];
      if (shared_ctl[DCC_BIT_GSS]) begin
        timer_gate <= timer_gate_pin;
      end else begin
        // Timer samples on its rising edge, so capture on the fall avoids a race
        timer_gate <= shared_ctl[DCC_BIT_SYNC] ? cmp2_synced_result : cmp2_result;
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_OFF_RESULT: assert property (!ctrl1[DCC_BIT_ON] |=> !cmp1_result)
    else $error("cmp1 result high while disabled");

  AST_POLARITY: assert property (
    ctrl2[DCC_BIT_ON] && ctrl2[DCC_BIT_POL] |=> cmp2_result == !$past(raw_sync[1]))
    else $error("cmp2 polarity not applied");

  AST_PIN_GATE: assert property (
    cmp1_pin_oe |-> $past(ctrl1[DCC_BIT_OE] && ctrl1[DCC_BIT_ON] && !port_direction[0]))
    else $error("cmp1 pin driven without all conditions");

  AST_BIT3_ZERO: assert property (!ctrl1[3] && !ctrl2[3])
    else $error("control bit 3 became set");

  AST_GATE_PIN: assert property (
    shared_ctl[DCC_BIT_GSS] |=> timer_gate == $past(timer_gate_pin))
    else $error("timer gate ignores gate pin");

  AST_SYNC_HOLD: assert property (
    !(timer_clk_q && !timer_clk) |=> $stable(cmp2_synced_result))
    else $error("synced result changed without timer fall");

  AST_FLAG_SET: assert property ($rose(mismatch[0]) |=> irq_flag[0])
    else $error("flag not set on mismatch edge");

  AST_MIRROR_QUIET: assert property (
    rd_take && araddr == DCC_OFF_SHARED && !do_write |=> $stable(access_latch))
    else $error("shared read disturbed mismatch latch");

  AST_ANALOG_ZERO: assert property (
    rd_take && araddr == DCC_OFF_PORT |=> (rdata[7:0] & $past(analog_sel)) == 8'h00)
    else $error("analog pin read nonzero");

endmodule // dcc_top

// file: tb/dcc_timer_model.sv
`timescale 1ns/1ps
module dcc_timer_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       timer_run,
  input  wire logic       timer_gate,
  output logic            timer_clk,
  output logic [7:0]      timer_count
);
  logic [1:0] div;
  // prescaled clock, stands low when stopped
  always_ff @(posedge aclk) begin
    if (!aresetn || !timer_run) begin
      div       <= 2'h0;
      timer_clk <= 1'b0;
    end else begin
      div <= div + 2'h1;
      if (div == 2'h3) begin
        timer_clk <= ~timer_clk;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_count <= 8'h00;
    end else if (timer_run && div == 2'h3 && !timer_clk && timer_gate) begin
      timer_count <= timer_count + 8'h01;
    end
  end
endmodule // dcc_timer_model

// file: tb/dual_comparator_control_test.sv
`timescale 1ns/1ps
module dual_comparator_control_test;
  import dcc_pkg::*;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, cmp1_raw, cmp2_raw, timer_clk;
  logic        timer_gate_pin, cmp1_enable, cmp2_enable, cmp1_ref_select;
  logic        cmp2_ref_select, cmp1_hysteresis_enable, cmp2_hysteresis_enable;
  logic        timer_alt_clock_select, cmp1_pin_out, cmp1_pin_oe, cmp2_pin_out;
  logic        cmp2_pin_oe, timer_gate, timer_run;
  logic [4:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, cmp1_channel_select, cmp2_channel_select, r;
  logic [7:0]  port_pins, timer_count, v;
  int          bad_count, compares;

  dcc_top uut (.*);
  dcc_timer_model timer (.*);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic conclude(input bit hung);
    if (hung) bad_count++;
    $display("Compares %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Master holds each channel until its own ready edge
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    awaddr  <= a;
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    // Ready left high so back-to-back calls never drive it twice in one step
    r = bresp;
    if (n >= 50) conclude(1);
  endtask

  task automatic rd(input logic [4:0] a);
    int n;
    n = 0;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    v = rdata[7:0];
    r = rresp;
    if (n >= 50) conclude(1);
  endtask

  task automatic t_reset();
    rd(DCC_OFF_SHARED);
    check(v, DCC_SHARED_RST);
    rd(DCC_OFF_CTRL1);
    check(v, DCC_CTRL_RST);
    rd(5'h1c);
    check({6'h0, r}, {6'h0, DCC_RESP_SLVERR});
    wr(5'h1c, 8'hff);
    check({6'h0, r}, {6'h0, DCC_RESP_SLVERR});
    $display("Reset test done");
  endtask

  task automatic t_ctrl();
    cmp1_raw <= 1'b1;
    wr(DCC_OFF_CTRL1, 8'hff);
    settle(6);
    rd(DCC_OFF_CTRL1);
    check(v, 8'hb7);
    check({cmp1_enable, cmp1_ref_select, cmp1_channel_select}, 8'h0f);
    wr(DCC_OFF_CTRL1, 8'ha4);
    settle(3);
    rd(DCC_OFF_CTRL1);
    check(v, 8'he4);
    for (int i = 0; i < 4; i++) begin
      wr(DCC_OFF_CTRL2, 8'h80 | 8'(i));
      settle(2);
      check({6'h0, cmp2_channel_select}, 8'(i));
      check({cmp2_enable, cmp2_ref_select}, 8'h02);
    end
    wr(DCC_OFF_CTRL2, 8'h94);
    settle(6);
    rd(DCC_OFF_CTRL2);
    check(v, 8'hd4);
    check({cmp2_enable, cmp2_ref_select}, 8'h03);
    wr(DCC_OFF_CTRL2, 8'h83);
    $display("Control test done");
  endtask

  task automatic t_pin();
    check({cmp1_pin_oe, cmp2_pin_oe}, 8'h00);
    wr(DCC_OFF_DIR, 8'h00);
    settle(3);
    check({cmp1_pin_oe, cmp1_pin_out}, 8'h03);
    wr(DCC_OFF_CTRL1, 8'h24);
    settle(3);
    check({cmp1_enable, cmp1_pin_oe}, 8'h00);
    rd(DCC_OFF_CTRL1);
    check(v, 8'h24);
    wr(DCC_OFF_CTRL1, 8'h84);
    settle(6);
    check({cmp1_pin_oe, cmp1_enable}, 8'h01);
    $display("Pin test done");
  endtask

  task automatic t_shared();
    wr(DCC_OFF_SHARED, 8'hff);
    settle(2);
    rd(DCC_OFF_SHARED);
    check(v, 8'h9f);
    check({timer_alt_clock_select, cmp1_hysteresis_enable}, 8'h03);
    check({6'h0, cmp2_hysteresis_enable}, 8'h01);
    wr(DCC_OFF_SHARED, 8'h02);
    settle(2);
    check({timer_alt_clock_select, cmp1_hysteresis_enable}, 8'h00);
    $display("Shared test done");
  endtask

  task automatic t_gate();
    timer_gate_pin <= 1'b1;
    settle(4);
    check({7'h0, timer_gate}, 8'h01);
    wr(DCC_OFF_SHARED, 8'h00);
    cmp2_raw <= 1'b1;
    settle(8);
    check({7'h0, timer_gate}, 8'h01);
    check({7'h0, cmp2_pin_out}, 8'h01);
    cmp2_raw <= 1'b0;
    settle(8);
    check({7'h0, timer_gate}, 8'h00);
    // sync set while comparator gates the timer
    wr(DCC_OFF_SHARED, 8'h01);
    cmp2_raw <= 1'b1;
    settle(10);
    check({7'h0, timer_gate}, 8'h00);
    timer_run <= 1'b1;
    settle(24);
    check({7'h0, timer_gate}, 8'h01);
    check({7'h0, timer_count != 8'h00}, 8'h01);
    timer_run <= 1'b0;
    $display("Gate test done");
  endtask

  task automatic t_port();
    port_pins <= 8'ha5;
    rd(DCC_OFF_PORT);
    check(v, 8'h00);
    wr(DCC_OFF_ANALOG, 8'h0f);
    rd(DCC_OFF_PORT);
    check(v, 8'ha0);
    $display("Port test done");
  endtask

  task automatic t_irq();
    wr(DCC_OFF_FLAGS, 8'h00);
    rd(DCC_OFF_CTRL1);
    cmp1_raw <= 1'b0;
    settle(8);
    rd(DCC_OFF_FLAGS);
    check(v, 8'h01);
    wr(DCC_OFF_FLAGS, 8'h00);
    rd(DCC_OFF_FLAGS);
    check(v, 8'h00);
    rd(DCC_OFF_SHARED);
    cmp1_raw <= 1'b1;
    settle(8);
    rd(DCC_OFF_FLAGS);
    check(v, 8'h00);
    $display("Flag test done");
  endtask

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, aresetn} = '0;
    {cmp1_raw, cmp2_raw, timer_gate_pin, timer_run} = '0;
    {awaddr, araddr, wdata, port_pins} = '0;
    wstrb = 4'hf;
    bad_count = 0;
    compares = 0;
    settle(4);
    aresetn <= 1'b1;
    settle(2);
    t_reset();
    t_ctrl();
    t_pin();
    t_shared();
    t_gate();
    t_port();
    t_irq();
    conclude(0);
  end
endmodule // dual_comparator_control_test
